// file: common/dmx_params.svh
// Constants of the data-move execution block: opcodes, field positions, address maps and reset values.
`ifndef DMX_PARAMS_SVH
`define DMX_PARAMS_SVH

// ****************************************************************
// Opcode patterns
// ****************************************************************
`define DMX_OP_LOAD_BANK 8'h01
`define DMX_OP_LOAD_WORK 8'h0E
`define DMX_OP_STORE_W 7'h37
`define DMX_OP_COPY_SRC 4'hC
`define DMX_OP_COPY_DST 4'hF

// ****************************************************************
// Field positions and widths
// ****************************************************************
`define DMX_ACCESS_BIT 8
`define DMX_BANK_LOW_W 4

// ****************************************************************
// Address map
// ****************************************************************
`define DMX_INDEX_LIMIT 8'h5F
`define DMX_ACCESS_SPLIT 8'h80
`define DMX_ACCESS_SPLIT_EXT 8'h60
`define DMX_ACCESS_HIGH_BANK 4'hF
`define DMX_UPPER_ZERO 4'h0

// ****************************************************************
// Reset values
// ****************************************************************
`define DMX_RST_BYTE 8'h00
`define DMX_RST_ADDR 12'h000
`define DMX_RST_WORD 16'h0000

`endif

// file: common/dmx_pkg.sv
// Types shared by the data-move execution block.
package dmx_pkg;

  // Phase of the instruction cycle.
  typedef enum logic [1:0] {
    DMX_Q1 = 2'b00,
    DMX_Q2 = 2'b01,
    DMX_Q3 = 2'b10,
    DMX_Q4 = 2'b11
  } dmx_phase_t;

  // Instruction being executed in the current cycle.
  typedef enum logic [2:0] {
    DMX_NONE = 3'b000,
    DMX_LOAD_BANK = 3'b001,
    DMX_LOAD_WORK = 3'b010,
    DMX_STORE_W = 3'b011,
    DMX_COPY_SRC = 3'b100,
    DMX_COPY_DST = 3'b101
  } dmx_op_t;

endpackage

// file: verilog/dmx_phase.sv
// Four-phase sequencer that splits each instruction cycle into Q1 to Q4.
`timescale 1ns/100ps
module dmx_phase
  import dmx_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Current phase.
  output dmx_phase_t phase
);

  // Step through the four phases, one per clock, starting at Q1 after reset.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      phase <= DMX_Q1;
    end else begin
      case (phase)
        DMX_Q1: phase <= DMX_Q2;
        DMX_Q2: phase <= DMX_Q3;
        DMX_Q3: phase <= DMX_Q4;
        DMX_Q4: phase <= DMX_Q1;
        default: phase <= DMX_Q1;
      endcase
    end
  end

endmodule

// file: verilog/dmx_exec.sv
// Decode and execute logic for the literal-load, store-working and file-to-file copy instructions.
`timescale 1ns/100ps
`include "dmx_params.svh"
module dmx_exec
  import dmx_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Instruction word from the fetch unit, sampled in Q1.
  input wire logic [15:0] instr,
  input wire logic instr_valid,
  // Core configuration and pointer used for indexed offset addressing.
  input wire logic ext_set_en,
  input wire logic [11:0] index_base,
  // Data memory port.
  output logic [11:0] mem_addr,
  output logic mem_re,
  output logic mem_we,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  // Core state and status.
  output logic [7:0] working_reg,
  output logic [7:0] bank_select_register,
  output logic status_we,
  output dmx_phase_t phase,
  output logic second_word_due,
  output logic decode_miss
);

  // ****************************************************************
  // Address formation
  // ****************************************************************

  // Forms the 12-bit data address of a one-word byte instruction.
  function automatic logic [11:0] dmx_file_addr(input logic acc, input logic [7:0] f, input logic [7:0] bank,
                                                input logic ext, input logic [11:0] base);
    logic [11:0] addr;
    addr = {bank[`DMX_BANK_LOW_W-1:0], f};
    if (!acc) begin
      if (ext && f <= `DMX_INDEX_LIMIT) begin
        addr = base + {4'h0, f};
      end else if (!ext && f < `DMX_ACCESS_SPLIT) begin
        addr = {4'h0, f};
      end else if (ext && f < `DMX_ACCESS_SPLIT_EXT) begin
        addr = {4'h0, f};
      end else begin
        addr = {`DMX_ACCESS_HIGH_BANK, f};
      end
    end
    return addr;
  endfunction

  // ****************************************************************
  // Phase sequencer
  // ****************************************************************

  dmx_phase u_phase (
    .clk(clk),
    .rstn(rstn),
    .phase(phase)
  );

  // ****************************************************************
  // Decode
  // ****************************************************************

  dmx_op_t op;
  dmx_op_t next_op;
  logic [15:0] ir;
  logic [11:0] copy_src;
  logic [7:0] copy_data;

  // Classifies the word offered in Q1; a copy destination word is honoured only after a source word.
  always_comb begin
    next_op = DMX_NONE;
    if (instr_valid) begin
      if (op == DMX_COPY_SRC) begin
        if (instr[15:12] == `DMX_OP_COPY_DST) begin
          next_op = DMX_COPY_DST;
        end
      end else if (instr[15:8] == `DMX_OP_LOAD_BANK) begin
        next_op = DMX_LOAD_BANK;
      end else if (instr[15:8] == `DMX_OP_LOAD_WORK) begin
        next_op = DMX_LOAD_WORK;
      end else if (instr[15:9] == `DMX_OP_STORE_W) begin
        next_op = DMX_STORE_W;
      end else if (instr[15:12] == `DMX_OP_COPY_SRC) begin
        next_op = DMX_COPY_SRC;
      end
    end
  end

  // Latches the instruction and its class at the end of Q1.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      op <= DMX_NONE;
      ir <= `DMX_RST_WORD;
    end else if (phase == DMX_Q1) begin
      op <= next_op;
      ir <= instr;
    end
  end

  // Flags words that this block does not execute, one pulse per Q1.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      decode_miss <= 1'b0;
    end else begin
      decode_miss <= (phase == DMX_Q1) && instr_valid && (next_op == DMX_NONE);
    end
  end

  // Tells the fetch unit that the next word belongs to a copy in progress.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      second_word_due <= 1'b0;
    end else if (phase == DMX_Q1) begin
      second_word_due <= (next_op == DMX_COPY_SRC);
    end
  end

  // ****************************************************************
  // Core registers
  // ****************************************************************

  // Loads the bank select register with the low nibble only, at the end of Q4.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bank_select_register <= `DMX_RST_BYTE;
    end else if (phase == DMX_Q4 && op == DMX_LOAD_BANK) begin
      bank_select_register <= {`DMX_UPPER_ZERO, ir[`DMX_BANK_LOW_W-1:0]};
    end
  end

  // Loads the working register from the literal at the end of Q4.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      working_reg <= `DMX_RST_BYTE;
    end else if (phase == DMX_Q4 && op == DMX_LOAD_WORK) begin
      working_reg <= ir[7:0];
    end
  end

  // None of these instructions ever updates the arithmetic flags.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status_we <= 1'b0;
    end else begin
      status_we <= 1'b0;
    end
  end

  // ****************************************************************
  // Copy source capture
  // ****************************************************************

  // Keeps the source address of a copy from the end of its first Q1.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      copy_src <= `DMX_RST_ADDR;
    end else if (phase == DMX_Q1 && next_op == DMX_COPY_SRC) begin
      copy_src <= instr[11:0];
    end
  end

  // Captures the source byte while the read strobe is up in Q3 of the first cycle.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      copy_data <= `DMX_RST_BYTE;
    end else if (phase == DMX_Q3 && op == DMX_COPY_SRC) begin
      copy_data <= mem_rdata;
    end
  end

  // ****************************************************************
  // Data memory port
  // ****************************************************************

  // Raises the read strobe for Q3 of a copy's first cycle only; the second cycle never reads.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mem_re <= 1'b0;
    end else begin
      mem_re <= (phase == DMX_Q2) && (op == DMX_COPY_SRC);
    end
  end

  // Raises the write strobe for the cycle after Q4 of a store or a copy's second cycle.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mem_we <= 1'b0;
    end else begin
      mem_we <= (phase == DMX_Q4) && (op == DMX_STORE_W || op == DMX_COPY_DST);
    end
  end

  // Drives the address and write data that go with each strobe.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mem_addr <= `DMX_RST_ADDR;
      mem_wdata <= `DMX_RST_BYTE;
    end else if (phase == DMX_Q2 && op == DMX_COPY_SRC) begin
      mem_addr <= copy_src;
    end else if (phase == DMX_Q4 && op == DMX_STORE_W) begin
      mem_addr <= dmx_file_addr(ir[`DMX_ACCESS_BIT], ir[7:0], bank_select_register, ext_set_en,
                                index_base);
      mem_wdata <= working_reg;
    end else if (phase == DMX_Q4 && op == DMX_COPY_DST) begin
      mem_addr <= ir[11:0];
      mem_wdata <= copy_data;
    end
  end

endmodule

// file: dv/dmx_sva.sv
// Concurrent checks on the ports of the data-move execution block.
`timescale 1ns/100ps
module dmx_sva
  import dmx_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Instruction port and configuration.
  input wire logic [15:0] instr,
  input wire logic instr_valid,
  input wire logic ext_set_en,
  // Data memory port.
  input wire logic [11:0] mem_addr,
  input wire logic mem_re,
  input wire logic mem_we,
  input wire logic [7:0] mem_wdata,
  // Core state and status.
  input wire logic [7:0] working_reg,
  input wire logic [7:0] bank_select_register,
  input wire logic status_we,
  input wire dmx_phase_t phase,
  input wire logic second_word_due
);
  logic take;
  // A fresh word is taken at the end of Q1 unless a copy still waits for its second word.
  assign take = phase == DMX_Q1 && instr_valid && !second_word_due;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // ********************
  // Assertions and cover points
  // ********************
  a_phase_step: assert property (1'b1 |=> phase == 2'($past(phase) + 2'd1))
    else $error("phase did not advance by one");
  a_bank_load: assert property (take && instr[15:8] == 8'h01 |-> ##4
    bank_select_register == {4'h0, $past(instr[3:0], 4)}) else $error("bank load wrong");
  a_bank_upper: assert property (bank_select_register[7:4] == 4'h0)
    else $error("bank upper bits set");
  a_work_load: assert property (take && instr[15:8] == 8'h0E |-> ##4
    working_reg == $past(instr[7:0], 4)) else $error("working load wrong");
  a_store_data: assert property (take && instr[15:9] == 7'h37 |-> ##4
    mem_we && mem_wdata == working_reg) else $error("store data wrong");
  a_store_bank: assert property (take && instr[15:8] == 8'h6F |-> ##4
    mem_addr == {bank_select_register[3:0], $past(instr[7:0], 4)}) else $error("banked address wrong");
  a_store_access: assert property (take && instr[15:7] == 9'h0DC && !ext_set_en |-> ##4
    mem_addr == {4'h0, $past(instr[7:0], 4)}) else $error("access address wrong");
  a_copy_dest: assert property (phase == DMX_Q1 && instr_valid && second_word_due &&
    instr[15:12] == 4'hF |-> ##4 mem_we && mem_addr == $past(instr[11:0], 4)) else $error("copy write wrong");
  a_read_first: assert property (mem_re |-> phase == DMX_Q3 && second_word_due)
    else $error("read outside first copy cycle");
  a_status_hold: assert property (!status_we)
    else $error("status write seen");
  c_store_write: cover property (mem_we && !second_word_due);
  c_copy_read: cover property (mem_re);
  c_bank_change: cover property ($changed(bank_select_register));
endmodule

bind dmx_exec dmx_sva i_dmx_sva (.clk(clk), .rstn(rstn), .instr(instr), .instr_valid(instr_valid),
  .ext_set_en(ext_set_en), .mem_addr(mem_addr), .mem_re(mem_re), .mem_we(mem_we), .mem_wdata(mem_wdata),
  .working_reg(working_reg), .bank_select_register(bank_select_register), .status_we(status_we),
  .phase(phase), .second_word_due(second_word_due));

// file: dv/dmx_mem_model.sv
// Behavioural data memory register file facing the execution block.
`timescale 1ns/100ps
module dmx_mem_model (
  // Clock.
  input wire logic clk,
  // Data memory port.
  input wire logic [11:0] mem_addr,
  input wire logic mem_re,
  input wire logic mem_we,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [4096];
  logic [7:0] junk = 8'h00;
  // Preloads every byte with its low address bits inverted in a fixed pattern.
  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem[i] = 8'(i) ^ 8'hA5;
    end
  end
  // Stores the byte at the edge ending the write strobe cycle.
  always @(posedge clk) begin
    junk <= ~junk;
    if (mem_we) begin
      mem[mem_addr] <= mem_wdata;
    end
  end
  // Outside a read the data lines toggle so a late sample cannot pass by luck.
  assign mem_rdata = mem_re ? mem[mem_addr] : junk;
endmodule

// file: dv/testbench.sv
// Self-checking testbench of the data-move execution block.
`timescale 1ns/100ps
module testbench;
  import dmx_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [15:0] instr = 16'h0000;
  logic instr_valid = 1'b0;
  logic ext_set_en = 1'b0;
  logic [11:0] index_base = 12'hFF0;
  logic [11:0] mem_addr;
  logic mem_re, mem_we, status_we, second_word_due, decode_miss;
  logic [7:0] mem_wdata, mem_rdata, working_reg, bank_select_register;
  dmx_phase_t phase;
  int mismatches = 0;
  int samples_checked = 0;
  dmx_exec i_dmx_exec (.clk(clk), .rstn(rstn), .instr(instr), .instr_valid(instr_valid), .ext_set_en(ext_set_en),
    .index_base(index_base), .mem_addr(mem_addr), .mem_re(mem_re), .mem_we(mem_we), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .working_reg(working_reg), .bank_select_register(bank_select_register),
    .status_we(status_we), .phase(phase), .second_word_due(second_word_due), .decode_miss(decode_miss));
  dmx_mem_model i_dmx_mem_model (.clk(clk), .mem_addr(mem_addr), .mem_re(mem_re), .mem_we(mem_we),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  // Clock of 100 ns period.
  initial begin
    forever #50 clk = ~clk;
  end
  task automatic stop_test;
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Presents one word for the next Q1 and returns at the edge that takes it.
  task automatic issue(input logic [15:0] word);
    @(negedge clk);
    while (phase !== DMX_Q4) @(negedge clk);
    @(posedge clk);
    instr <= word;
    instr_valid <= 1'b1;
    @(posedge clk);
    instr_valid <= 1'b0;
    instr <= ~word;
  endtask
  // Runs one store and judges the write strobe cycle four cycles after the take.
  task automatic store(input logic a, input logic [7:0] f, input logic [11:0] exp);
    issue({7'h37, a, f});
    repeat (4) @(negedge clk);
    chk("mem_we", 12'h001, 12'(mem_we));
    chk("mem_addr", exp, mem_addr);
    chk("mem_wdata", 12'h05A, 12'(mem_wdata));
    chk("status_we", 12'h000, 12'(status_we));
  endtask
  task automatic test_load_bank;
    logic [7:0] lits [2] = '{8'hA5, 8'h3C};
    for (int i = 0; i < 2; i++) begin
      issue({8'h01, lits[i]});
      repeat (4) @(negedge clk);
      chk("bank_select_register", {8'h00, lits[i][3:0]}, 12'(bank_select_register));
    end
  endtask
  task automatic test_load_work;
    issue(16'h0E5A);
    repeat (4) @(negedge clk);
    chk("working_reg", 12'h05A, 12'(working_reg));
  endtask
  task automatic test_store_banked;
    store(1'b1, 8'hFF, 12'hCFF);
    @(negedge clk);
    chk("working_reg", 12'h05A, 12'(working_reg));
    chk("stored_byte", 12'h05A, 12'(i_dmx_mem_model.mem[12'hCFF]));
  endtask
  task automatic test_store_access;
    store(1'b0, 8'h7F, 12'h07F);
    store(1'b0, 8'h80, 12'hF80);
    @(posedge clk);
    ext_set_en <= 1'b1;
    store(1'b0, 8'h5F, 12'h04F);
    store(1'b0, 8'h60, 12'hF60);
    @(posedge clk);
    ext_set_en <= 1'b0;
  endtask
  task automatic test_copy;
    issue(16'hC123);
    issue(16'hFABC);
    repeat (4) @(negedge clk);
    chk("mem_addr", 12'hABC, mem_addr);
    chk("mem_wdata", 12'h086, 12'(mem_wdata));
    @(negedge clk);
    chk("copied_byte", 12'h086, 12'(i_dmx_mem_model.mem[12'hABC]));
  endtask
  // A copy whose second word lacks the destination prefix must be dropped.
  task automatic test_copy_abort;
    issue(16'hC200);
    issue(16'h0E77);
    @(negedge clk);
    chk("decode_miss", 12'h001, 12'(decode_miss));
    repeat (3) @(negedge clk);
    chk("mem_we", 12'h000, 12'(mem_we));
    chk("working_reg", 12'h05A, 12'(working_reg));
  endtask
  // Main sequence: reset for five cycles, then every scenario in turn.
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    test_load_bank();
    test_load_work();
    test_store_banked();
    test_store_access();
    test_copy();
    test_copy_abort();
    stop_test();
  end
  // Watchdog well beyond the fewer than one hundred cycles the scenarios need.
  initial begin
    repeat (2000) @(posedge clk);
    mismatches++;
    stop_test();
  end
endmodule
